// >>> design/fir_filter_regs.vh
// Register map, field positions and fixed figures of the decimation filter.
// Included by every design file; holds definitions only.
`ifndef FIR_FILTER_REGS_VH
`define FIR_FILTER_REGS_VH

// Word indices (byte address = 4 x index)
`define IDX_CTRL 10'h000
`define IDX_STATUS 10'h001
`define IDX_CHCFG_HI 7'h01
`define IDX_COEF_FIRST 10'h05A
`define IDX_COEF_LAST 10'h0B9

// Global control fields
`define CTRL_UCE_BIT 0
`define CTRL_SRC_BIT 1
`define CTRL_RESET 2'h0

// Per-channel configuration fields
`define CFG_ORATE_LSB 0
`define CFG_FRATE_LSB 4
`define CFG_SET_LSB 8
`define CFG_PARITY_BIT 12
`define CFG_APPLY_BIT 16
`define CFG_WMASK 17'h11777
`define CFG_RESET 17'h00000

// Output-rate select codes
`define ORATE_BYPASS 3'h0
`define ORATE_DIV2 3'h1
`define ORATE_DIV4 3'h2
`define ORATE_DIV8 3'h3

// Built-in coefficient set codes
`define SET_LP_FS4 3'h0
`define SET_HP_FS4 3'h1
`define SET_LP_FS8 3'h2
`define SET_BP1_FS8 3'h3
`define SET_BP2_FS8 3'h4
`define SET_HP_3FS8 3'h5

// Filter geometry
`define NUM_CHAN 8
`define NUM_UCOEF 12
`define NUM_COEF_REGS 96
`define DLINE_LEN 24
`define MIRROR_EVEN 5'd23
`define MIRROR_ODD 5'd22
`define LAST_STEP 4'd11
`define FRAC_BITS 11
`define ROUND_HALF 30'h00000400

`endif

// >>> design/fir_coeff_rom.v
// Fixed coefficient sets of the built-in filters, h0 in the low bits.
// Assumes a select that is stable while a filter pass runs.
`timescale 1ns/100ps
`default_nettype none
`include "fir_filter_regs.vh"

module fir_coeff_rom #(
  parameter [143:0] SET_LP2 = {12'h400, 12'h28C, 12'h000, 12'hF2C, 12'h000, 12'h07C,
                               12'h000, 12'hFBC, 12'h000, 12'h020, 12'h000, 12'hFF4},
  parameter [143:0] SET_HP2 = {12'h400, 12'hD74, 12'h000, 12'h0D4, 12'h000, 12'hF84,
                               12'h000, 12'h044, 12'h000, 12'hFE0, 12'h000, 12'h00C},
  parameter [143:0] SET_LP4 = {12'h130, 12'h118, 12'h0E0, 12'h098, 12'h048, 12'h008,
                               12'hFE0, 12'hFD4, 12'hFDC, 12'hFEC, 12'hFF8, 12'hFFC},
  parameter [143:0] SET_BP1 = {12'h0F0, 12'hFA0, 12'hF40, 12'h010, 12'h0A0, 12'h050,
                               12'hFA8, 12'hFB0, 12'h010, 12'h030, 12'h008, 12'hFF8},
  parameter [143:0] SET_BP2 = {12'h0F0, 12'h060, 12'hF40, 12'hFF0, 12'h0A0, 12'hFB0,
                               12'hFA8, 12'h050, 12'h010, 12'hFD0, 12'h008, 12'h008},
  parameter [143:0] SET_HP8 = {12'h200, 12'hEC0, 12'h000, 12'h060, 12'h000, 12'hFC0,
                               12'h000, 12'h028, 12'h000, 12'hFE8, 12'h000, 12'h008}
) (
  input wire [2:0] set_sel,
  output reg [143:0] coefs
);

  // Unlisted set codes fall back to the half-band low-pass
  always @* begin
    case (set_sel)
      `SET_HP_FS4: coefs = SET_HP2;
      `SET_LP_FS8: coefs = SET_LP4;
      `SET_BP1_FS8: coefs = SET_BP1;
      `SET_BP2_FS8: coefs = SET_BP2;
      `SET_HP_3FS8: coefs = SET_HP8;
      default: coefs = SET_LP2;
    endcase
  end

endmodule
`default_nettype wire

// >>> design/fir_tap_step.v
// One multiply-accumulate step of the symmetric filter, plus output scaling.
// Purely combinational; the caller registers the accumulator.
`timescale 1ns/100ps
`default_nettype none
`include "fir_filter_regs.vh"

module fir_tap_step (
  input wire [11:0] tap_a,
  input wire [11:0] tap_b,
  input wire pair,
  input wire [11:0] coef,
  input wire [29:0] acc_in,
  output wire [29:0] acc_out,
  output reg [11:0] sat_out
);

  wire signed [12:0] pre_sum;
  wire signed [24:0] prod;
  wire signed [29:0] rounded;
  wire signed [18:0] scaled;

  // Centre tap of the odd-length form is counted once
  assign pre_sum = $signed({tap_a[11], tap_a}) +
                   (pair ? $signed({tap_b[11], tap_b}) : 13'sd0);
  assign prod = pre_sum * $signed(coef);
  assign acc_out = acc_in + {{5{prod[24]}}, prod};
  assign rounded = $signed(acc_in) + $signed(`ROUND_HALF);
  assign scaled = rounded[29:`FRAC_BITS];

  // Saturate rather than wrap, a wrapped sample looks like a full-scale spike
  always @* begin
    if (scaled > 19'sd2047) begin
      sat_out = 12'h7FF;
    end else if (scaled < -19'sd2048) begin
      sat_out = 12'h800;
    end else begin
      sat_out = scaled[11:0];
    end
  end

endmodule
`default_nettype wire

// >>> design/fir_decim_filter.v
// Eight-channel decimating symmetric FIR with an AHB-Lite register slave.
// Assumes samples on hclk, sample_valid spaced at least 14 cycles apart.
//
// Functional notes
// - Rate 001/000, set 000, odd taps: built-in low-pass, decimate by two.
// - Rate 001/000, set 001, odd taps: built-in high-pass, decimate by two.
// - Rate 010/001, set 010, even taps: built-in low-pass fs/8, decimate four.
// - Rate 010/001, set 011, even taps: first band-pass, decimate by four.
// - Rate 010/001, set 100, even taps: second band-pass, decimate by four.
// - Rate 010/001, set 101, odd taps: high-pass 3fs/8 up, decimate four.
// - Custom and channel-use set: user coefficients, decimate 2, 4, 8 or bypass.
// - Default filter is 24 symmetric taps with 12-bit signed coefficients.
// - Tap parity set to one gives a 23-tap filter.
// - Built-in selections use fixed coefficient sets, nothing to load.
// - Decimation optional; rate, band and coefficient source are programmable.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "fir_filter_regs.vh"

module fir_decim_filter (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [95:0] sample_in,
  input wire sample_valid,
  output wire [95:0] filt_out,
  output wire [7:0] filt_valid
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MAC = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  integer i;

  reg ap_wr_q;
  reg rd_pend_q;
  reg [9:0] ap_idx_q;
  reg [1:0] ctrl_q;
  reg [16:0] chcfg_q [0:7];
  reg [11:0] coef_q [0:95];
  reg [31:0] rd_data;
  wire [7:0] busy;
  wire take;
  wire wr_en;
  wire ap_is_coef;
  wire ap_is_cfg;
  wire [9:0] ap_slot;
  wire use_custom;

  assign take = hsel & htrans[1] & hready;
  assign wr_en = ap_wr_q & hready;
  assign ap_is_coef = (ap_idx_q >= `IDX_COEF_FIRST) && (ap_idx_q <= `IDX_COEF_LAST);
  assign ap_is_cfg = (ap_idx_q[9:3] == `IDX_CHCFG_HI);
  assign ap_slot = ap_idx_q - `IDX_COEF_FIRST;
  // Custom coefficients need both the global enable and the source select
  assign use_custom = ctrl_q[`CTRL_UCE_BIT] & ctrl_q[`CTRL_SRC_BIT];

  // Bus front end: writes finish with no wait, reads insert one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ap_idx_q <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      if (rd_pend_q) begin
        hrdata <= rd_data;
        hreadyout <= 1'b1;
        rd_pend_q <= 1'b0;
        ap_wr_q <= 1'b0;
      end else if (take) begin
        ap_idx_q <= haddr[11:2];
        ap_wr_q <= hwrite & (hsize == 3'h2);
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end else if (hready) begin
        ap_wr_q <= 1'b0;
      end
    end
  end

  // Register file writes; unmapped indices are ignored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `CTRL_RESET;
      for (i = 0; i < `NUM_CHAN; i = i + 1) begin
        chcfg_q[i] <= `CFG_RESET;
      end
      for (i = 0; i < `NUM_COEF_REGS; i = i + 1) begin
        coef_q[i] <= 12'h000;
      end
    end else if (wr_en) begin
      if (ap_idx_q == `IDX_CTRL) begin
        ctrl_q <= hwdata[1:0];
      end
      if (ap_is_cfg) begin
        chcfg_q[ap_idx_q[2:0]] <= hwdata[16:0] & `CFG_WMASK;
      end
      if (ap_is_coef) begin
        coef_q[ap_slot[6:0]] <= hwdata[11:0];
      end
    end
  end

  // Read mux, sampled in the read wait state so a preceding write is seen
  always @* begin
    rd_data = 32'h00000000;
    if (ap_idx_q == `IDX_CTRL) begin
      rd_data = {30'h00000000, ctrl_q};
    end else if (ap_idx_q == `IDX_STATUS) begin
      rd_data = {23'h000000, use_custom, busy};
    end else if (ap_is_cfg) begin
      rd_data = {15'h0000, chcfg_q[ap_idx_q[2:0]]};
    end else if (ap_is_coef) begin
      rd_data = {20'h00000, coef_q[ap_slot[6:0]]};
    end
  end

  genvar gc;
  genvar gk;
  generate
    for (gc = 0; gc < `NUM_CHAN; gc = gc + 1) begin : chan
      reg [11:0] dl_q [0:23];
      // Own loop variable, so no two channel processes share one driver
      integer j;
      reg [2:0] st_q;
      reg [2:0] cnt_q;
      reg [3:0] k_q;
      reg [29:0] acc_q;
      reg [11:0] out_q;
      reg vld_q;
      reg [2:0] n_m1;
      wire [16:0] cfg;
      wire [2:0] orate;
      wire odd;
      wire apply;
      wire [143:0] rom_bus;
      wire [143:0] user_bus;
      wire [143:0] coef_bus;
      wire [4:0] mirror;
      wire [4:0] idx_b;
      wire [29:0] acc_nx;
      wire [11:0] sat;

      assign cfg = chcfg_q[gc];
      assign orate = cfg[`CFG_ORATE_LSB +: 3];
      assign odd = cfg[`CFG_PARITY_BIT];
      assign apply = cfg[`CFG_APPLY_BIT];

      for (gk = 0; gk < `NUM_UCOEF; gk = gk + 1) begin : ucoef
        assign user_bus[gk*12 +: 12] = coef_q[gc*`NUM_UCOEF + gk];
      end

      fir_coeff_rom u_rom (
        .set_sel(cfg[`CFG_SET_LSB +: 3]),
        .coefs(rom_bus)
      );

      // Only h0..h11 are stored; symmetry supplies the mirrored taps
      assign coef_bus = use_custom ? user_bus : rom_bus;
      assign mirror = odd ? `MIRROR_ODD : `MIRROR_EVEN;
      assign idx_b = mirror - {1'b0, k_q};

      fir_tap_step u_step (
        .tap_a(dl_q[k_q]),
        .tap_b(dl_q[idx_b]),
        .pair(~(odd & (k_q == `LAST_STEP))),
        .coef(coef_bus[k_q*12 +: 12]),
        .acc_in(acc_q),
        .acc_out(acc_nx),
        .sat_out(sat)
      );

      // Decimation factor comes from the output-rate select alone
      always @* begin
        case (orate)
          `ORATE_DIV2: n_m1 = 3'h1;
          `ORATE_DIV4: n_m1 = 3'h3;
          `ORATE_DIV8: n_m1 = 3'h7;
          default: n_m1 = 3'h0;
        endcase
      end

      // A sample arriving mid-pass would shift taps under the accumulator
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          for (j = 0; j < `DLINE_LEN; j = j + 1) begin
            dl_q[j] <= 12'h000;
          end
        end else if (sample_valid) begin
          dl_q[0] <= sample_in[gc*12 +: 12];
          for (j = 1; j < `DLINE_LEN; j = j + 1) begin
            dl_q[j] <= dl_q[j-1];
          end
        end
      end

      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_q <= ST_IDLE;
          cnt_q <= 3'h0;
          k_q <= 4'h0;
          acc_q <= 30'h00000000;
          out_q <= 12'h000;
          vld_q <= 1'b0;
        end else begin
          vld_q <= 1'b0;
          case (st_q)
            ST_IDLE: begin
              if (sample_valid && !apply) begin
                out_q <= sample_in[gc*12 +: 12];
                vld_q <= 1'b1;
                cnt_q <= 3'h0;
              end else if (sample_valid) begin
                if (cnt_q >= n_m1) begin
                  cnt_q <= 3'h0;
                  k_q <= 4'h0;
                  acc_q <= 30'h00000000;
                  st_q <= ST_MAC;
                end else begin
                  cnt_q <= cnt_q + 3'h1;
                end
              end
            end
            ST_MAC: begin
              acc_q <= acc_nx;
              k_q <= k_q + 4'h1;
              if (k_q == `LAST_STEP) begin
                st_q <= ST_DONE;
              end
            end
            ST_DONE: begin
              out_q <= sat;
              vld_q <= 1'b1;
              st_q <= ST_IDLE;
            end
            default: begin
              st_q <= ST_IDLE;
            end
          endcase
        end
      end

      assign busy[gc] = ~st_q[0];
      assign filt_out[gc*12 +: 12] = out_q;
      assign filt_valid[gc] = vld_q;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> verification/fir_decim_filter_assertions.sv
// Checker for the decimation filter: bus handshake and output stream.
// Sees only the top ports; bound below.
`timescale 1ns/100ps
`default_nettype none
module fir_decim_filter_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sample_valid,
  input wire logic [95:0] filt_out,
  input wire logic [7:0] filt_valid
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd = hsel & htrans[1] & hready & !hwrite;
  wire logic wr = hsel & htrans[1] & hready & hwrite;
  AST_RESP_OKAY: assert property (hresp == 1'h0)
    else $error("bus response not okay");
  AST_READ_WAIT: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (wr |=> hreadyout)
    else $error("write stalled");
  AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  AST_RDATA_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  AST_VALID_PULSE: assert property (filt_valid[0] |=> !filt_valid[0])
    else $error("output strobe too long");
  AST_OUT_HOLD: assert property (!filt_valid[0] |-> $stable(filt_out[11:0]))
    else $error("output moved without strobe");
  AST_VALID_CAUSE: assert property (filt_valid[0] |-> $past(sample_valid) || $past(sample_valid, 14))
    else $error("output strobe without sample");
  COV_READ: cover property (rd);
  COV_OUT: cover property (filt_valid[0]);
  COV_PASS: cover property (sample_valid ##14 filt_valid[0]);
endmodule
bind fir_decim_filter fir_decim_filter_assertions i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
  .filt_out(filt_out), .filt_valid(filt_valid));
`default_nettype wire

// >>> verification/adc_sample_source.sv
// Converter pipeline model: one 12-bit word to all eight channels.
// Expects go as a one-cycle request; the bench spaces requests.
`timescale 1ns/100ps
`default_nettype none
module adc_sample_source (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [11:0] value,
  output logic [95:0] sample_in,
  output logic sample_valid
);
  // Between samples the word toggles so stale data cannot pass for fresh
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_valid <= 1'h0;
      sample_in <= 96'h0;
    end else begin
      sample_valid <= go;
      sample_in <= go ? {8{value}} : ~sample_in;
    end
  end
endmodule
`default_nettype wire

// >>> verification/adc_decimation_fir_filter_bench.sv
// Bench for the decimation filter: registers, rates, tap parity.
// AHB-Lite master here; samples come from the source model.
`timescale 1ns/100ps
`default_nettype none
`include "fir_filter_regs.vh"
module adc_decimation_fir_filter_bench;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, go = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [11:0] value = 12'h0, last = 12'h0;
  logic [15:0] rows [0:9] = '{16'h1001, 16'h1101, 16'h0212, 16'h0312, 16'h0412,
    16'h1512, 16'h0001, 16'h1012, 16'h0043, 16'h0000};
  logic [7:0] last_v = 8'h00;
  logic [95:0] last_w = 96'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, sample_valid;
  wire logic [95:0] filt_out, sample_in;
  wire logic [7:0] filt_valid;
  int err_count = 0, n_tests = 0, outs = 0, base = 0;
  always #5 hclk = ~hclk;
  fir_decim_filter i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_in(sample_in),
    .sample_valid(sample_valid), .filt_out(filt_out), .filt_valid(filt_valid));
  adc_sample_source i_src (.hclk(hclk), .hresetn(hresetn), .go(go), .value(value),
    .sample_in(sample_in), .sample_valid(sample_valid));
  always @(posedge hclk) begin
    if (filt_valid[0] === 1'h1) begin
      outs <= outs + 1;
      last <= filt_out[11:0];
      last_v <= filt_valid;
      last_w <= filt_out;
    end
  end
  task give_verdict;
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // No cycle count is assumed; a hung slave is caught by the watchdog
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // Spacing of 17 cycles keeps clear of the 14-cycle pass
  task smp(input logic [11:0] v);
    go <= 1'h1;
    value <= v;
    @(posedge hclk);
    go <= 1'h0;
    repeat (16) @(posedge hclk);
  endtask
  task set_cfg(input logic [31:0] ctrl, input logic [31:0] cfg);
    bus(1'h1, 32'h0, ctrl);
    bus(1'h1, 32'h20, cfg);
    base = outs;
  endtask
  task t_regs;
    bus(1'h0, 32'h20, 32'h0);
    chk(rd, `CFG_RESET);
    bus(1'h1, 32'h20, 32'hFFFFFFFF);
    bus(1'h0, 32'h20, 32'h0);
    chk(rd, `CFG_WMASK);
    hsize <= 3'h1;
    bus(1'h1, 32'h20, 32'h0);
    hsize <= 3'h2;
    bus(1'h0, 32'h20, 32'h0);
    chk(rd, `CFG_WMASK);
    bus(1'h1, 32'h3FC, 32'hFFFFFFFF);
    bus(1'h0, 32'h3FC, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, 32'h2E4, 32'hFFFFFFFF);
    bus(1'h0, 32'h2E4, 32'h0);
    chk(rd, 32'hFFF);
  endtask
  task t_pass;
    set_cfg(32'h0, 32'h0);
    smp(12'h5A5);
    smp(12'h0F0);
    chk(outs - base, 2);
    chk(last, 12'h0F0);
    chk(last_v, 32'hFF);
    chk(last_w === {8{12'h0F0}}, 32'h1);
  endtask
  task t_rates;
    for (int i = 0; i < 10; i++) begin
      set_cfg(i > 5 ? 32'h3 : 32'h0, 32'h10000 | rows[i]);
      for (int j = 0; j < 8; j++) smp(12'h100 + j[11:0]);
      chk(outs - base, 8 >> rows[i][1:0]);
    end
  endtask
  // Only h11 set: an even filter sees the impulse twice, an odd one once
  task t_parity;
    bus(1'h1, 32'h194, 32'h400);
    for (int p = 0; p < 2; p++) begin
      set_cfg(32'h3, 32'h10000 | (p << 12));
      bus(1'h0, 32'h4, 32'h0);
      chk(rd, 32'h100);
      for (int j = 0; j < 37; j++) begin
        smp(j == 24 ? 12'h100 : 12'h0);
        if (j == 35) chk(last, 12'h080);
      end
      chk(last, p ? 12'h000 : 12'h080);
    end
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs;
    t_pass;
    t_rates;
    t_parity;
    give_verdict;
  end
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
